// [src/bof_defs.svh]
/*
 Offsets, field positions, reset values and timing counts for the bridge option flags block.
 Assumes inclusion by bare name from the design files.
*/
`ifndef BOF_DEFS_SVH
`define BOF_DEFS_SVH

`define BOF_OFF_OPT        8'h00
`define BOF_OFF_CTRL       8'h04
`define BOF_OFF_STAT       8'h08
`define BOF_BIT_PAGE8      5
`define BOF_BIT_POLL       4
`define BOF_BIT_BUSYDLY    3
`define BOF_BIT_SHORTPKT   2
`define BOF_OPT_RESET      8'h07
`define BOF_MODE_PAGE_NUM  8'h08
`define BOF_CLK_MHZ        100
`define BOF_BUSY_DLY_MS    120
`define BOF_BUSY_DLY_CYC   (`BOF_BUSY_DLY_MS * 1000 * `BOF_CLK_MHZ)

`endif

// [src/bof_pkg.sv]
/*
 Types for the bridge option flags block.
 Assumes the defs header is available for constants.
*/
package bof_pkg;
	typedef enum logic [3:0] {
		BOF_ST_IDLE = 4'h1,
		BOF_ST_WAIT = 4'h2,
		BOF_ST_SHRT = 4'h4,
		BOF_ST_STAL = 4'h8
	} bof_state_t;

	typedef struct packed {
		logic page8;
		logic poll;
		logic busy_dly;
		logic short_pkt;
	} bof_flags_t;
endpackage

// [src/bof_flags_if.sv]
/*
 Carrier for the latched option flags between the top and its decoder.
 Assumes one clock domain.
*/
`timescale 1ns/100ps
`default_nettype none
interface bof_flags_if;
	import bof_pkg::*;
	logic [7:0] opt_byte;
	logic       load;
	bof_flags_t flags;
	logic       held;
	modport src (output opt_byte, output load, input flags, input held);
	modport dec (input opt_byte, input load, output flags, output held);
endinterface
`default_nettype wire

// [src/bof_decode.sv]
/*
 Captures the option byte once per reset and splits out bits 5 to 2.
 Assumes load pulses once the configuration byte has been read.
*/
`timescale 1ns/100ps
`default_nettype none
`include "bof_defs.svh"
module bof_decode
	import bof_pkg::*;
(
	input  wire logic    hclk,
	input  wire logic    hresetn,
	bof_flags_if.dec     fif
);
	// First load wins; later loads ignored so flags stay stable
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			fif.flags <= '0;
			fif.held  <= 1'b0;
		end else if (fif.load && !fif.held) begin
			fif.flags.page8     <= fif.opt_byte[`BOF_BIT_PAGE8];
			fif.flags.poll      <= fif.opt_byte[`BOF_BIT_POLL];
			fif.flags.busy_dly  <= fif.opt_byte[`BOF_BIT_BUSYDLY];
			fif.flags.short_pkt <= fif.opt_byte[`BOF_BIT_SHORTPKT];
			fif.held            <= 1'b1;
		end
	end

	property p_stable;
		@(posedge hclk) disable iff (!hresetn) fif.held |=> $stable(fif.flags) && fif.held;
	endproperty
	a_stable: assert property (p_stable) else $error("flags changed after capture");
endmodule
`default_nettype wire

// [src/bof_top.sv]
/*
 Bridge option flags: AHB-Lite register access to the option byte and the
 behaviour it steers (mode page 8 offer, INTRQ vs polling, BUSY delay,
 short packet before IN STALL).
 Assumes a single AHB-Lite master, word transfers, and drive/USB event
 pins synchronous to hclk.
*/
`timescale 1ns/100ps
`default_nettype none
`include "bof_defs.svh"
module bof_top
	import bof_pkg::*;
#(
	parameter int BUSY_DLY_CYC = `BOF_BUSY_DLY_CYC
)(
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [7:0]  haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	input  wire logic [7:0]  mode_page_req,
	input  wire logic        cmd_wait_req,
	input  wire logic        intrq,
	input  wire logic        status_busy,
	input  wire logic        drq_read,
	input  wire logic        len_mismatch,
	input  wire logic        in_stall_req,
	output logic             page_offer,
	output logic             cmd_done,
	output logic             status_poll,
	output logic             drq_hold,
	output logic             short_pkt_send,
	output logic             in_stall
);
	bof_flags_if fif ();
	bof_state_t  st_r;
	logic [31:0] dly_r;
	logic [7:0]  opt_r;
	logic        ap_valid_r;
	logic        ap_write_r;
	logic [7:0]  ap_addr_r;
	logic        wait_r;

	// Bus decode used in five places
	function automatic logic is_reg(input logic [7:0] a, input logic [7:0] off);
		return a == off;
	endfunction

	////////////////////////////////////////////////////////////////////////////////////////////////////
	// AHB-Lite slave, zero wait states, always OKAY
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ap_valid_r <= 1'b0;
			ap_write_r <= 1'b0;
			ap_addr_r  <= 8'h00;
		end else if (hready) begin
			ap_valid_r <= hsel && htrans[1];
			ap_write_r <= hwrite;
			ap_addr_r  <= haddr;
		end
	end

	// Option byte: writable until loaded, then locked
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			opt_r <= `BOF_OPT_RESET;
		else if (ap_valid_r && ap_write_r && is_reg(ap_addr_r, `BOF_OFF_OPT) && !fif.held)
			opt_r <= hwdata[7:0];
	end

	assign fif.opt_byte = opt_r;
	assign fif.load = ap_valid_r && ap_write_r && is_reg(ap_addr_r, `BOF_OFF_CTRL) && hwdata[0];

	bof_decode u_dec (
		.hclk    (hclk),
		.hresetn (hresetn),
		.fif     (fif)
	);

	// Read data registered in the address phase
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata    <= 32'h0000_0000;
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end else if (hready && hsel && htrans[1] && !hwrite) begin
			if (is_reg(haddr, `BOF_OFF_OPT))
				hrdata <= {24'h000000, opt_r};
			else if (is_reg(haddr, `BOF_OFF_CTRL))
				hrdata <= {31'h0, fif.held};
			else if (is_reg(haddr, `BOF_OFF_STAT))
				hrdata <= {26'h0, st_r, fif.flags.poll, wait_r};
			else
				hrdata <= 32'h0000_0000;
		end
	end

	////////////////////////////////////////////////////////////////////////////////////////////////////
	// Mode page 8 (write caching) offered only when enabled
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			page_offer <= 1'b0;
		else
			page_offer <= (mode_page_req == `BOF_MODE_PAGE_NUM) ? fif.flags.page8 : 1'b1;
	end

	// Command completion: INTRQ, or status polling with INTRQ ignored
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wait_r      <= 1'b0;
			cmd_done    <= 1'b0;
			status_poll <= 1'b0;
		end else begin
			cmd_done    <= 1'b0;
			status_poll <= wait_r && fif.flags.poll;
			if (cmd_wait_req)
				wait_r <= 1'b1;
			else if (wait_r && (fif.flags.poll ? !status_busy : intrq)) begin
				wait_r   <= 1'b0;
				cmd_done <= 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////////////////////////
	// BUSY delay and short-packet-before-stall sequencer
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st_r           <= BOF_ST_IDLE;
			dly_r          <= 32'h0000_0000;
			drq_hold       <= 1'b0;
			short_pkt_send <= 1'b0;
			in_stall       <= 1'b0;
		end else begin
			short_pkt_send <= 1'b0;
			in_stall       <= 1'b0;
			unique case (st_r)
				BOF_ST_IDLE: begin
					if (drq_read && len_mismatch && fif.flags.busy_dly) begin
						st_r     <= BOF_ST_WAIT;
						dly_r    <= 32'h0000_0000;
						drq_hold <= 1'b1;
					end else if (in_stall_req) begin
						if (fif.flags.short_pkt) begin
							st_r           <= BOF_ST_SHRT;
							short_pkt_send <= 1'b1;
						end else begin
							in_stall <= 1'b1;
						end
					end
				end
				BOF_ST_WAIT: begin
					// Early release once busy clears: the delay is an upper bound
					if (!status_busy || dly_r == 32'(BUSY_DLY_CYC - 1)) begin
						st_r     <= BOF_ST_IDLE;
						drq_hold <= 1'b0;
					end else
						dly_r <= dly_r + 32'h0000_0001;
				end
				BOF_ST_SHRT: begin
					st_r     <= BOF_ST_STAL;
					in_stall <= 1'b1;
				end
				BOF_ST_STAL: st_r <= BOF_ST_IDLE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////////////////////////
	property p_page8_off;
		@(posedge hclk) disable iff (!hresetn)
			(mode_page_req == `BOF_MODE_PAGE_NUM && !fif.flags.page8) |=> !page_offer;
	endproperty
	a_page8_off: assert property (p_page8_off) else $error("page 8 offered while disabled");

	property p_page8_on;
		@(posedge hclk) disable iff (!hresetn)
			(mode_page_req == `BOF_MODE_PAGE_NUM && fif.flags.page8) |=> page_offer;
	endproperty
	a_page8_on: assert property (p_page8_on) else $error("page 8 not offered while enabled");

	property p_poll_ignores_intrq;
		@(posedge hclk) disable iff (!hresetn)
			(wait_r && fif.flags.poll && status_busy && !cmd_wait_req) |=> !cmd_done;
	endproperty
	a_poll_ignores_intrq: assert property (p_poll_ignores_intrq) else $error("done while polled busy");

	property p_intrq_wait;
		@(posedge hclk) disable iff (!hresetn)
			(wait_r && !fif.flags.poll && !intrq && !cmd_wait_req) |=> !cmd_done;
	endproperty
	a_intrq_wait: assert property (p_intrq_wait) else $error("done without INTRQ");

	property p_no_delay;
		@(posedge hclk) disable iff (!hresetn)
			(st_r == BOF_ST_IDLE && !fif.flags.busy_dly) |=> st_r != BOF_ST_WAIT;
	endproperty
	a_no_delay: assert property (p_no_delay) else $error("busy delay while disabled");

	sequence s_short;
		short_pkt_send ##1 in_stall;
	endsequence
	property p_short_then_stall;
		@(posedge hclk) disable iff (!hresetn)
			(st_r == BOF_ST_IDLE && in_stall_req && fif.flags.short_pkt
			 && !(drq_read && len_mismatch && fif.flags.busy_dly)) |=> s_short;
	endproperty
	a_short_then_stall: assert property (p_short_then_stall) else $error("no short packet before stall");

	property p_no_short;
		@(posedge hclk) disable iff (!hresetn) !fif.flags.short_pkt |-> !short_pkt_send;
	endproperty
	a_no_short: assert property (p_no_short) else $error("short packet forced while disabled");

	property p_opt_locked;
		@(posedge hclk) disable iff (!hresetn) fif.held |=> $stable(opt_r);
	endproperty
	a_opt_locked: assert property (p_opt_locked) else $error("option byte changed after load");
endmodule
`default_nettype wire

// [test/bof_drive_model.sv]
/*
 Drive-side model: BUSY and INTRQ answer to a started command.
 Assumes go is a one-cycle pulse synchronous to hclk.
*/
`timescale 1ns/100ps
`default_nettype none
module bof_drive_model (
	input  wire logic       hclk,
	input  wire logic       hresetn,
	input  wire logic       go,
	input  wire logic [7:0] lat,
	output logic            intrq,
	output logic            status_busy
);
	logic [7:0] cnt_r;
	// INTRQ rises early, before BUSY clears, so polling and waiting differ
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cnt_r       <= 8'h00;
			intrq       <= 1'b0;
			status_busy <= 1'b0;
		end else if (go) begin
			cnt_r       <= lat;
			intrq       <= 1'b0;
			status_busy <= 1'b1;
		end else if (cnt_r != 8'h00) begin
			cnt_r       <= cnt_r - 8'h01;
			intrq       <= (cnt_r <= lat - 8'h03);
			status_busy <= (cnt_r != 8'h01);
		end
	end
endmodule
`default_nettype wire

// [test/tb_bridge_option_flags.sv]
/*
 Self-checking bench for the option flags block: bus, page, wait, delay, stall.
 Assumes bof_top with a short BUSY delay count and the drive model beside it.
*/
`timescale 1ns/100ps
`default_nettype none
module tb_bridge_option_flags;
	import bof_pkg::*;
	logic        hclk, hresetn, hsel, hwrite, rd_ph, go, cmd_wait_req, drq_read, len_mismatch, in_stall_req;
	logic        hreadyout, intrq, status_busy, page_offer, cmd_done, drq_hold, short_pkt_send, in_stall;
	logic        hresp, status_poll;
	logic [7:0]  haddr, mode_page_req, lat, opt;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic [31:0] hwdata, hrdata;
	logic [31:0] exp_q[$];
	int          mismatches, checks_done, n;

	bof_top #(.BUSY_DLY_CYC(20)) dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
		.hready(hreadyout), .hrdata, .hreadyout, .hresp, .mode_page_req, .cmd_wait_req, .intrq,
		.status_busy, .drq_read, .len_mismatch, .in_stall_req, .page_offer, .cmd_done,
		.status_poll, .drq_hold, .short_pkt_send, .in_stall);
	bof_drive_model drv (.hclk, .hresetn, .go, .lat, .intrq, .status_busy);

	////////////////////////////////////////////////////////////////
	// Clock
	initial begin
		hclk = 1'b0;
		forever #5 hclk = ~hclk;
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			mismatches++;
			$display("ERROR %0t seen %0h expected %0h", $time, seen, exp);
		end
	endtask
	task automatic print_verdict;
		if (mismatches == 0 && checks_done > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	task automatic tick(input int k);
		repeat (k) @(posedge hclk);
	endtask
	// Bounded wait for hreadyout at an edge; a hang ends the run
	task automatic edge_rdy;
		int i;
		i = 0;
		do begin tick(1); i++; end while (hreadyout !== 1'b1 && i < 50);
		if (i >= 50) begin mismatches++; print_verdict(); end
	endtask
	// One single word transfer; for reads d is the expected data
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'b1; haddr <= a; hwrite <= w; htrans <= 2'h2;
		edge_rdy();
		htrans <= 2'h0; hwdata <= d; rd_ph <= !w;
		if (!w) exp_q.push_back(d);
		edge_rdy();
		rd_ph <= 1'b0;
	endtask
	function automatic logic [31:0] pop;
		return exp_q.size() ? exp_q.pop_front() : 32'hFFFFFFFF;
	endfunction

	////////////////////////////////////////////////////////////////
	// Monitor: oldest note against each read or event pulse
	always @(posedge hclk) begin
		if (rd_ph === 1'b1 && hreadyout === 1'b1) chk(hrdata, pop());
		if (rd_ph === 1'b1 && hreadyout === 1'b1) chk(hresp, 0);
		if ((cmd_done | short_pkt_send | in_stall) === 1'b1) chk({29'h0, cmd_done, short_pkt_send, in_stall}, pop());
	end

	////////////////////////////////////////////////////////////////
	// Main sequence: each reset loads one option byte, corners first
	initial begin
		{hsel, hwrite, rd_ph, go, cmd_wait_req, drq_read, len_mismatch, in_stall_req} = '0;
		hresetn = 1'b0; haddr = 8'h00; htrans = 2'h0; hsize = 3'h2; hwdata = 32'h0;
		mode_page_req = 8'h00; lat = 8'h00; mismatches = 0; checks_done = 0;
		n = $urandom(95963);
		for (int k = 0; k < 8; k++) begin
			opt = (k == 0) ? 8'h3C : (k == 1) ? 8'h00 : 8'($urandom);
			if (k > 0) begin
				tick(1);
				hresetn <= 1'b0;
			end
			tick(2);
			hresetn <= 1'b1;
			bus(1'b0, 8'h00, 32'h07);
			bus(1'b0, 8'h0C, 32'h0);
			bus(1'b1, 8'h00, {24'h0, opt});
			bus(1'b1, 8'h04, 32'h1);
			bus(1'b1, 8'h00, {24'h0, ~opt}); // Ignored once held
			bus(1'b0, 8'h04, 32'h1);
			bus(1'b0, 8'h00, {24'h0, opt});
			mode_page_req <= 8'h08; tick(3); chk(page_offer, opt[5]);
			mode_page_req <= 8'h05; tick(3); chk(page_offer, 1);
			// Stall, with or without the forced short packet
			exp_q.push_back(opt[2] ? 32'h2 : 32'h1);
			if (opt[2]) exp_q.push_back(32'h1);
			in_stall_req <= 1'b1; tick(1); in_stall_req <= 0; tick(4);
			// Drive wait: INTRQ early, BUSY clears after 12 cycles
			exp_q.push_back(32'h4);
			lat <= 8'd12; go <= 1'b1; cmd_wait_req <= 1'b1; tick(1); go <= 0; cmd_wait_req <= 0;
			n = 0;
			do begin
				tick(1);
				n++;
				if (n == 2) chk(status_poll, opt[4]);
			end while (cmd_done !== 1'b1 && n < 40);
			chk({n >= 40, n > 10}, {1'b0, opt[4]});
			if (n >= 40) print_verdict();
			// DRQ read with BUSY stuck: hold only if enabled, then expiry
			len_mismatch <= 1'($urandom); lat <= 8'd60; go <= 1'b1; tick(1);
			go <= 1'b0; drq_read <= 1'b1; tick(1); drq_read <= 1'b0;
			tick(2); chk(drq_hold, opt[3] & len_mismatch);
			chk(status_poll, 0);
			tick(24); chk(drq_hold, 0);
			chk(exp_q.size(), 0);
		end
		print_verdict();
	end
endmodule
`default_nettype wire
